/* File: bench/usrsi_assertions.sv */
// Port-level checker for the resume, suspend and interrupt-mask block
`timescale 1ns/1ps

module usrsi_assertions
  import usrsi_pkg::*;
#(
  parameter int EP_N     = 16,
  parameter int TAIL_LEN = 8
) (
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  input wire logic                        wb_cyc_i,
  input wire logic                        wb_stb_i,
  input wire logic                        wb_we_i,
  input wire logic [7:0]                  wb_adr_i,
  input wire logic [3:0]                  wb_sel_i,
  input wire logic [31:0]                 wb_dat_i,
  input wire logic [31:0]                 wb_dat_o,
  input wire logic                        wb_ack_o,
  input wire logic [usrsi_pkg::CTL_W-1:0] ctl_evt_i,
  input wire logic [2*EP_N-1:0]           ep_evt_i,
  input wire logic                        dev_low_speed_i,
  input wire logic                        dev_full_speed_i,
  input wire logic                        resume_drive_o,
  input wire logic                        bus_suspend_o,
  input wire logic                        irq_o
);
  // Accepted request, and full-word control writes
  logic tk;
  logic wctl;
  assign tk   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wctl = tk & wb_we_i & (wb_adr_i == OFF_CTRL) & (wb_sel_i == 4'hf);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ***********************************************************
  // Checks
  // ***********************************************************
  property p_ack_once; tk |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i & wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_unmapped; tk && !wb_we_i && wb_adr_i > OFF_GSTAT |=> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_resume_on; wctl && wb_dat_i[CTRL_RESUME_BIT] |-> ##[1:3] resume_drive_o; endproperty
  a_resume_on: assert property (p_resume_on) else $error("resume drive missing");
  // Host tail must outlast the request, yet end in bounded time
  property p_host_tail;
    wctl && wb_dat_i[2:0] == 3'h1 && resume_drive_o |=> resume_drive_o [*4] ##[1:30] !resume_drive_o;
  endproperty
  a_host_tail: assert property (p_host_tail) else $error("host resume tail wrong");
  property p_dev_stop; wctl && wb_dat_i[2:0] == 3'h0 |-> ##[1:3] !resume_drive_o; endproperty
  a_dev_stop: assert property (p_dev_stop) else $error("device resume not stopped");
  property p_susp_on; wctl && wb_dat_i[2:0] == 3'h5 |-> ##[1:4] bus_suspend_o; endproperty
  a_susp_on: assert property (p_susp_on) else $error("suspend not entered");
  property p_susp_dev; wctl && !wb_dat_i[CTRL_HOST_BIT] |-> ##[3:5] !bus_suspend_o; endproperty
  a_susp_dev: assert property (p_susp_dev) else $error("suspend outside host");
  property p_irq_off;
    tk && wb_we_i && wb_adr_i == OFF_GMASK_DS && wb_dat_i[GRP_ALL_BIT] |-> ##3 !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq after all masked");
endmodule

bind usrsi_top usrsi_assertions #(.EP_N(EP_N), .TAIL_LEN(TAIL_LEN)) chk_u (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .ctl_evt_i, .ep_evt_i, .dev_low_speed_i, .dev_full_speed_i,
  .resume_drive_o, .bus_suspend_o, .irq_o);

/* File: bench/usrsi_top_bench.sv */
// Self-checking bench: register traffic, events, resume and suspend outputs
`timescale 1ns/1ps

module usrsi_top_bench;
  import usrsi_pkg::*;
  localparam int TL = 8;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h0;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] dat   = 32'h0;
  logic [11:0] cf    = 12'h0;
  logic [31:0] ef    = 32'h0;
  logic [1:0]  spd   = 2'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [11:0] ce;
  logic [31:0] ee;
  logic        lo, fu, ack, irq, rdrv, susp;
  int          error_cnt = 0;
  int          compares  = 0;

  always #50 clk_i = ~clk_i;

  usrsi_top #(.EP_N(16), .TAIL_LEN(TL)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack),
    .ctl_evt_i(ce), .ep_evt_i(ee), .dev_low_speed_i(lo), .dev_full_speed_i(fu),
    .resume_drive_o(rdrv), .bus_suspend_o(susp), .irq_o(irq));

  usrsi_usb_peer peer_u (
    .clk_i(clk_i), .ctl_fire_i(cf), .ep_fire_i(ef), .spd_i(spd),
    .ctl_evt_o(ce), .ep_evt_o(ee), .low_o(lo), .full_o(fu));

  // ***********************************************************
  // Bus and compare tasks
  // ***********************************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Classic cycle: hold until ack is sampled, then release for a cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    rdat = q;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Fire inputs pulse for one cycle, the peer stretches events to two, then status has time to settle
  task automatic fire(input logic [11:0] c, input logic [31:0] e);
    @(posedge clk_i);
    cf <= c;
    ef <= e;
    @(posedge clk_i);
    cf <= 12'h0;
    ef <= 32'h0;
    idle(5);
  endtask

  task automatic summarize;
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    idle(5000);
    error_cnt++;
    summarize();
  end

  // Main sequence; request hold times are shortened, so 20 ms is not honoured
  initial begin
    idle(6);
    rst_i <= 1'b0;
    rd(OFF_CTRL, 32'h0);
    rd(OFF_CMASK, 32'h0);
    rd(OFF_EMASK, 32'h0);
    rd(8'h3c, 32'h0);
    wr(OFF_CMASK_EN, 32'h0a5);
    wr(OFF_CMASK_EN, 32'h100);
    rd(OFF_CMASK, 32'h1a5);
    wr(OFF_CMASK_DS, 32'h005);
    rd(OFF_CMASK, 32'h1a0);
    wr(OFF_EMASK_EN, 32'h0001_8000);
    rd(OFF_EMASK, 32'h0001_8000);
    rd(OFF_CMASK, 32'h1a0);
    wr(OFF_GMASK_DS, 32'h8000_0000);
    rd(OFF_CMASK, 32'h0);
    wr(OFF_EMASK_DS, 32'hffff_ffff);
    wr(OFF_GMASK_EN, 32'h0000_ffff);
    rd(OFF_EMASK, 32'h000f_000f);
    wr(OFF_GMASK_EN, 32'h0001_0000);
    rd(OFF_CMASK, 32'hfff);
    wr(OFF_GMASK_DS, 32'h0000_0101);
    rd(OFF_EMASK, 32'h000f_000e);
    wr(OFF_GMASK_DS, 32'h8000_0000);
    wr(OFF_EMASK_DS, 32'hffff_ffff);
    for (int i = 0; i < CTL_W; i++) begin
      fire(12'h1 << i, 32'h0);
      rd(OFF_CSTAT, 32'h1 << i);
    end
    rd(OFF_CSTAT, 32'h0);
    fire(12'h010, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_CMASK_EN, 32'h010);
    idle(3);
    chk({31'h0, irq}, 32'h1);
    fire(12'h0, 32'h0000_0020);
    wr(OFF_CMASK_DS, 32'h010);
    idle(3);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_EMASK_EN, 32'h20);
    idle(3);
    chk({31'h0, irq}, 32'h1);
    rd(OFF_ESTAT, 32'h20);
    wr(OFF_ESTAT, 32'h20);
    idle(3);
    chk({31'h0, irq}, 32'h0);
    rd(OFF_GSTAT, 32'h0001_0000);
    rd(OFF_CSTAT, 32'h0);
    wr(OFF_CTRL, 32'h2);
    idle(3);
    rd(OFF_STATUS, 32'h2);
    wr(OFF_CTRL, 32'h0);
    idle(3);
    chk({31'h0, rdrv}, 32'h0);
    spd <= 2'h1;
    wr(OFF_CTRL, 32'h3);
    idle(3);
    rd(OFF_STATUS, 32'h6);
    wr(OFF_CTRL, 32'h1);
    idle(1);
    rd(OFF_STATUS, 32'h16);
    idle(TL + 4);
    chk({31'h0, rdrv}, 32'h0);
    spd <= 2'h2;
    idle(4);
    rd(OFF_STATUS, 32'h8);
    spd <= 2'h0;
    idle(4);
    rd(OFF_STATUS, 32'h0);
    wr(OFF_CTRL, 32'h5);
    idle(3);
    rd(OFF_STATUS, 32'h1);
    wr(OFF_CTRL, 32'h4);
    idle(3);
    chk({31'h0, susp}, 32'h0);
    spd <= 2'h2;
    idle(4);
    rd(OFF_STATUS, 32'h0);
    summarize();
  end
endmodule

/* File: bench/usrsi_usb_peer.sv */
// Behavioural model of the USB peer that raises bus events and shows its speed
`timescale 1ns/1ps

module usrsi_usb_peer (
  input  wire logic        clk_i,
  input  wire logic [11:0] ctl_fire_i,
  input  wire logic [31:0] ep_fire_i,
  input  wire logic [1:0]  spd_i,
  output logic      [11:0] ctl_evt_o,
  output logic      [31:0] ep_evt_o,
  output logic             low_o,
  output logic             full_o
);
  logic [11:0] c_r = 12'h0;
  logic [31:0] e_r = 32'h0;
  // Stretch each event a cycle so the synchroniser cannot drop it
  always_ff @(posedge clk_i) begin
    c_r <= ctl_fire_i;
    e_r <= ep_fire_i;
  end
  assign ctl_evt_o = ctl_fire_i | c_r;
  assign ep_evt_o  = ep_fire_i | e_r;
  // Pull-up state of the attached peer, code 0 means none attached
  assign low_o  = (spd_i == 2'h1);
  assign full_o = (spd_i == 2'h2);
endmodule

/* File: hw/usrsi_pkg.sv */
// Package with register map, field layout and timing constants for the resume/suspend/mask block
package usrsi_pkg;

  // ***********************************************************
  // Register offsets (byte addresses)
  // ***********************************************************
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_CMASK_EN = 8'h08;
  localparam logic [7:0] OFF_CMASK_DS = 8'h0c;
  localparam logic [7:0] OFF_CMASK    = 8'h10;
  localparam logic [7:0] OFF_CSTAT    = 8'h14;
  localparam logic [7:0] OFF_EMASK_EN = 8'h18;
  localparam logic [7:0] OFF_EMASK_DS = 8'h1c;
  localparam logic [7:0] OFF_EMASK    = 8'h20;
  localparam logic [7:0] OFF_ESTAT    = 8'h24;
  localparam logic [7:0] OFF_GMASK_EN = 8'h28;
  localparam logic [7:0] OFF_GMASK_DS = 8'h2c;
  localparam logic [7:0] OFF_GSTAT    = 8'h30;

  // ***********************************************************
  // Control register fields
  // ***********************************************************
  localparam int CTRL_HOST_BIT    = 0;
  localparam int CTRL_RESUME_BIT  = 1;
  localparam int CTRL_SUSPEND_BIT = 2;

  // Status register fields
  localparam int ST_SUSP_BIT      = 0;
  localparam int ST_RESUME_BIT    = 1;
  localparam int ST_SPEED_LSB     = 2;
  localparam int ST_TAIL_BIT      = 4;

  // Speed codes
  localparam logic [1:0] SPEED_LOW_CODE     = 2'h1;
  localparam logic [1:0] SPEED_FULL_CODE    = 2'h2;
  localparam logic [1:0] speed_unknown_code = 2'h0;

  // ***********************************************************
  // Control interrupt sources
  // ***********************************************************
  localparam int CTL_W           = 12;
  localparam int CI_VBUS_ERR     = 0;
  localparam int CI_SESSION      = 1;
  localparam int CI_SESSION_END  = 2;
  localparam int CI_DISCONNECT   = 3;
  localparam int CI_CONNECT      = 4;
  localparam int CI_SOF          = 5;
  localparam int CI_BABBLE       = 6;
  localparam int CI_RESET        = 7;
  localparam int CI_RESUME       = 8;
  localparam int CI_SUSPEND      = 9;
  localparam int CI_MODE_DETECT  = 10;
  localparam int CI_POWER_FAULT  = 11;

  // Legacy grouped mask fields
  localparam int GRP_EPS          = 4;
  localparam int GRP_HOST_IN_LSB  = 0;
  localparam int GRP_HOST_OUT_LSB = 4;
  localparam int GRP_DEV_IN_LSB   = 8;
  localparam int GRP_DEV_OUT_LSB  = 12;
  localparam int GRP_STATUS_BIT   = 16;
  localparam int GRP_ALL_BIT      = 31;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int CLK_HZ            = 10_000_000;
  localparam int TAIL_US           = 1000;
  localparam int TAIL_CYC          = (TAIL_US * (CLK_HZ / 1_000_000));
  localparam int HOST_RESUME_MS    = 20;
  localparam int DEV_RESUME_MIN_MS = 10;
  localparam int DEV_RESUME_MAX_MS = 15;

endpackage

/* File: hw/usrsi_top.sv */
// Resume, suspend, speed report and interrupt masks of a dual-role USB controller
// Overview of operation
// - In host mode a set resume request drives resume signaling; software holds it at least 20 ms.
// - In device mode a set resume request leaves suspend and signals resume; software clears it after 10 to 15 ms.
// - In host mode clearing the resume request lets the block finish the resume sequence on the bus.
// - In host mode the block reports low speed, full speed or an unknown-speed code.
// - In host mode a suspend command puts the bus into suspend; software issues it only as host.
// - The legacy mask groups sources into IN endpoints, OUT endpoints and status, with an all-sources selector.
// - The legacy mask reaches endpoints 0 to 3 only; higher endpoints use the separate masks.
// - A control mask, separate from the endpoint mask, enables each control source on its own.
// - An endpoint mask holds per-endpoint bits for host and device without touching the control mask.
// - Disabled sources stop raising the interrupt while enabled ones still do.
// - Control sources are VBUS error, session start/end, disconnect, connect, SOF, babble, reset, resume, suspend, mode detect, power fault.
// - Reading the control or legacy status clears each pending control source that has no new event in the same cycle.
`timescale 1ns/1ps

module usrsi_top #(
  parameter int EP_N     = 16,
  parameter int TAIL_LEN = usrsi_pkg::TAIL_CYC
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [7:0]                  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic [usrsi_pkg::CTL_W-1:0] ctl_evt_i,
  input  wire logic [2*EP_N-1:0]           ep_evt_i,
  input  wire logic                        dev_low_speed_i,
  input  wire logic                        dev_full_speed_i,
  output logic                             resume_drive_o,
  output logic                             bus_suspend_o,
  output logic                             irq_o
);
  import usrsi_pkg::*;

  // ***********************************************************
  // Bus decode
  // ***********************************************************
  logic        acc;
  logic        wr;
  logic        rd;
  logic [31:0] wmask;
  logic [31:0] ctrl_r;
  logic [CTL_W-1:0] cmask_r;
  logic [CTL_W-1:0] cstat_r;
  logic [2*EP_N-1:0] emask_r;
  logic [2*EP_N-1:0] estat_r;
  logic [1:0]  speed_r;
  logic [2:0]  lspd_s1_r;
  logic [2:0]  lspd_s2_r;
  logic [CTL_W-1:0] cev_s1_r;
  logic [CTL_W-1:0] cev_s2_r;
  logic [2*EP_N-1:0] eev_s1_r;
  logic [2*EP_N-1:0] eev_s2_r;
  logic [31:0] rdata;
  logic [31:0] tail_cnt_r;
  logic        tail_r;
  logic        resume_q_r;
  logic [2*EP_N-1:0] gsel;
  logic [31:0] gstat;

  // One-cycle acknowledge; ack drop breaks a back-to-back repeat
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = acc && wb_we_i;
  assign rd  = acc && !wb_we_i;

  // Byte-lane mask from sel
  always_comb begin
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  // ***********************************************************
  // Input synchronisers
  // ***********************************************************
  // Speed pins and events come from the USB side, two stages each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lspd_s1_r <= 3'h0;
      lspd_s2_r <= 3'h0;
      cev_s1_r  <= '0;
      cev_s2_r  <= '0;
      eev_s1_r  <= '0;
      eev_s2_r  <= '0;
    end else begin
      lspd_s1_r <= {1'b0, dev_full_speed_i, dev_low_speed_i};
      lspd_s2_r <= lspd_s1_r;
      cev_s1_r  <= ctl_evt_i;
      cev_s2_r  <= cev_s1_r;
      eev_s1_r  <= ep_evt_i;
      eev_s2_r  <= eev_s1_r;
    end
  end

  // ***********************************************************
  // Control register
  // ***********************************************************
  // Mode, resume request, suspend command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (wr && wb_adr_i == OFF_CTRL) begin
      ctrl_r <= ((ctrl_r & ~wmask) | (wb_dat_i & wmask)) & 32'h0000_0007;
    end
  end

  // ***********************************************************
  // Resume and suspend signaling
  // ***********************************************************
  // Resume drives while requested, in either role
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resume_q_r <= 1'b0;
    end else begin
      resume_q_r <= ctrl_r[CTRL_RESUME_BIT];
    end
  end

  // Host completion tail after the request drops; timing of the request itself is software's duty
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tail_cnt_r <= 32'h0;
      tail_r     <= 1'b0;
    end else if (ctrl_r[CTRL_RESUME_BIT]) begin
      tail_cnt_r <= 32'h0;
      tail_r     <= 1'b0;
    end else if (resume_q_r && ctrl_r[CTRL_HOST_BIT]) begin
      tail_cnt_r <= TAIL_LEN[31:0];
      tail_r     <= 1'b1;
    end else if (tail_cnt_r > 32'h1) begin
      tail_cnt_r <= tail_cnt_r - 32'h1;
    end else begin
      tail_cnt_r <= 32'h0;
      tail_r     <= 1'b0;
    end
  end

  // Outputs registered; a resume request, its bridge cycle or the host tail also forces suspend low
  // Delayed request bridges the one cycle before the host tail starts, so the drive never gaps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resume_drive_o <= 1'b0;
      bus_suspend_o  <= 1'b0;
    end else begin
      resume_drive_o <= ctrl_r[CTRL_RESUME_BIT] || tail_r
                        || (resume_q_r && ctrl_r[CTRL_HOST_BIT]);
      bus_suspend_o  <= ctrl_r[CTRL_HOST_BIT] && ctrl_r[CTRL_SUSPEND_BIT] && !ctrl_r[CTRL_RESUME_BIT]
                        && !tail_r && !resume_q_r;
    end
  end

  // ***********************************************************
  // Speed report
  // ***********************************************************
  // Only meaningful as host; otherwise unknown
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_r <= speed_unknown_code;
    end else if (!ctrl_r[CTRL_HOST_BIT]) begin
      speed_r <= speed_unknown_code;
    end else if (lspd_s2_r[1]) begin
      speed_r <= SPEED_FULL_CODE;
    end else if (lspd_s2_r[0]) begin
      speed_r <= SPEED_LOW_CODE;
    end else begin
      speed_r <= speed_unknown_code;
    end
  end

  // ***********************************************************
  // Interrupt masks
  // ***********************************************************
  // Legacy group selection mapped onto endpoints 0..3 only
  always_comb begin
    gsel = '0;
    for (int i = 0; i < GRP_EPS; i++) begin
      gsel[i]        = wb_dat_i[GRP_HOST_IN_LSB + i] || wb_dat_i[GRP_DEV_IN_LSB + i]
                       || wb_dat_i[GRP_ALL_BIT];
      gsel[EP_N + i] = wb_dat_i[GRP_HOST_OUT_LSB + i] || wb_dat_i[GRP_DEV_OUT_LSB + i]
                       || wb_dat_i[GRP_ALL_BIT];
    end
  end

  // Control mask: enable/disable strobes change only selected bits; legacy status or all-sources writes set or clear every bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmask_r <= '0;
    end else if (wr && wb_adr_i == OFF_CMASK_EN) begin
      cmask_r <= cmask_r | wb_dat_i[CTL_W-1:0];
    end else if (wr && wb_adr_i == OFF_CMASK_DS) begin
      cmask_r <= cmask_r & ~wb_dat_i[CTL_W-1:0];
    end else if (wr && wb_adr_i == OFF_GMASK_EN && (wb_dat_i[GRP_STATUS_BIT] || wb_dat_i[GRP_ALL_BIT])) begin
      cmask_r <= '1;
    end else if (wr && wb_adr_i == OFF_GMASK_DS && (wb_dat_i[GRP_STATUS_BIT] || wb_dat_i[GRP_ALL_BIT])) begin
      cmask_r <= '0;
    end
  end

  // Endpoint mask: IN in low half, OUT in high half
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      emask_r <= '0;
    end else if (wr && wb_adr_i == OFF_EMASK_EN) begin
      emask_r <= emask_r | wb_dat_i[2*EP_N-1:0];
    end else if (wr && wb_adr_i == OFF_EMASK_DS) begin
      emask_r <= emask_r & ~wb_dat_i[2*EP_N-1:0];
    end else if (wr && wb_adr_i == OFF_GMASK_EN) begin
      emask_r <= emask_r | gsel;
    end else if (wr && wb_adr_i == OFF_GMASK_DS) begin
      emask_r <= emask_r & ~gsel;
    end
  end

  // ***********************************************************
  // Sticky status
  // ***********************************************************
  // Events win over the clear-on-read in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cstat_r <= '0;
    end else if (rd && (wb_adr_i == OFF_CSTAT || wb_adr_i == OFF_GSTAT)) begin
      cstat_r <= cev_s2_r;
    end else begin
      cstat_r <= cstat_r | cev_s2_r;
    end
  end

  // Endpoint status: cleared by writing one, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      estat_r <= '0;
    end else if (wr && wb_adr_i == OFF_ESTAT) begin
      estat_r <= (estat_r & ~wb_dat_i[2*EP_N-1:0]) | eev_s2_r;
    end else begin
      estat_r <= estat_r | eev_s2_r;
    end
  end

  // Legacy status view of endpoints 0..3 and the status group
  always_comb begin
    gstat = 32'h0;
    for (int i = 0; i < GRP_EPS; i++) begin
      gstat[GRP_HOST_IN_LSB + i]  = estat_r[i] && ctrl_r[CTRL_HOST_BIT];
      gstat[GRP_DEV_IN_LSB + i]   = estat_r[i] && !ctrl_r[CTRL_HOST_BIT];
      gstat[GRP_HOST_OUT_LSB + i] = estat_r[EP_N + i] && ctrl_r[CTRL_HOST_BIT];
      gstat[GRP_DEV_OUT_LSB + i]  = estat_r[EP_N + i] && !ctrl_r[CTRL_HOST_BIT];
    end
    gstat[GRP_STATUS_BIT] = |cstat_r;
  end

  // Level interrupt from unmasked sticky bits only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(cstat_r & cmask_r) || |(estat_r & emask_r);
    end
  end

  // ***********************************************************
  // Read data
  // ***********************************************************
  always_comb begin
    rdata = 32'h0;
    case (wb_adr_i)
      OFF_CTRL:   rdata = ctrl_r;
      OFF_STATUS: begin
        rdata[ST_SUSP_BIT]                 = bus_suspend_o;
        rdata[ST_RESUME_BIT]               = resume_drive_o;
        rdata[ST_SPEED_LSB +: 2]           = speed_r;
        rdata[ST_TAIL_BIT]                 = tail_r;
      end
      OFF_CMASK:  rdata[CTL_W-1:0]   = cmask_r;
      OFF_CSTAT:  rdata[CTL_W-1:0]   = cstat_r;
      OFF_EMASK:  rdata[2*EP_N-1:0]  = emask_r;
      OFF_ESTAT:  rdata[2*EP_N-1:0]  = estat_r;
      OFF_GSTAT:  rdata              = gstat;
      default:    rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (rd) begin
      wb_dat_o <= rdata;
    end
  end

endmodule
